// ==== adcrd_pkg.sv ====
package adcrd_pkg;

  localparam int        ADCRD_RES_W    = 14;
  localparam int        ADCRD_SUB_W    = 2;
  localparam int        ADCRD_FRAME_W  = 24;
  localparam int        ADCRD_CNT_W    = 5;
  // falling edges counted after select falls
  localparam bit [4:0]  ADCRD_CNT_RESET = 5'h00;
  localparam bit [4:0]  ADCRD_CNT_MAX   = 5'h18;
  // msb appears after this many falling edges; conversion is then done
  localparam bit [4:0]  ADCRD_CONV_DONE = 5'h08;
  localparam bit [4:0]  ADCRD_LAST_BIT  = 5'h17;
  localparam bit [4:0]  ADCRD_SUB_START = 5'h16;
  localparam bit [7:0]  ADCRD_LEAD_BYTE = 8'h00;
  localparam bit [23:0] ADCRD_FRAME_RESET = 24'h000000;

  typedef enum logic [1:0] {
    ADCRD_SHUTDOWN = 2'b01,
    ADCRD_ACTIVE   = 2'b10
  } adcrd_state_e;

  typedef struct packed {
    adcrd_state_e state;
    logic [23:0]  frame;
    logic [4:0]   count;
    logic         dout;
    logic         doutEn;
    logic         busy;
    logic         shutdown;
    logic         abortPulse;
  } adcrd_core_s;

  localparam adcrd_core_s ADCRD_CORE_RESET = '{
    state:      ADCRD_SHUTDOWN,
    frame:      ADCRD_FRAME_RESET,
    count:      ADCRD_CNT_RESET,
    dout:       1'b0,
    doutEn:     1'b0,
    busy:       1'b0,
    shutdown:   1'b1,
    abortPulse: 1'b0
  };

  typedef struct packed {
    logic csMeta;
    logic csSync;
    logic csPrev;
    logic sclkMeta;
    logic sclkSync;
    logic sclkPrev;
  } adcrd_sync_s;

  // select idles high, clock idles low
  localparam adcrd_sync_s ADCRD_SYNC_RESET = 6'b111000;

endpackage : adcrd_pkg

// ==== adcrd_link_if.sv ====
`timescale 1ns/100ps
interface adcrd_link_if;
  logic csLow;
  logic csFall;
  logic csRise;
  logic sclkFall;
  logic sclkRise;

  modport sync (output csLow, output csFall, output csRise, output sclkFall, output sclkRise);
  modport core (input csLow, input csFall, input csRise, input sclkFall, input sclkRise);
endinterface : adcrd_link_if

// ==== adcrd_pin_sync.sv ====
`timescale 1ns/100ps
module adcrd_pin_sync
  import adcrd_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst,
  input  wire logic  csN,
  input  wire logic  sclk,
  adcrd_link_if.sync lnk
);

  adcrd_sync_s q;
  adcrd_sync_s next_q;

  always_comb begin
    next_q          = q;
    next_q.csMeta   = csN;
    next_q.csSync   = q.csMeta;
    next_q.csPrev   = q.csSync;
    next_q.sclkMeta = sclk;
    next_q.sclkSync = q.sclkMeta;
    next_q.sclkPrev = q.sclkSync;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= ADCRD_SYNC_RESET;
    end else begin
      q <= next_q;
    end
  end

  // edges judged from the second and third stages, never the metastable one
  assign lnk.csLow    = ~q.csSync;
  assign lnk.csFall   = q.csPrev & ~q.csSync;
  assign lnk.csRise   = ~q.csPrev & q.csSync;
  assign lnk.sclkFall = q.sclkPrev & ~q.sclkSync;
  assign lnk.sclkRise = ~q.sclkPrev & q.sclkSync;

endmodule : adcrd_pin_sync

// ==== adcrd_readout.sv ====
`timescale 1ns/100ps
module adcrd_readout
  import adcrd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic [13:0] convResult,
  input  wire logic [1:0]  convSubBits,
  output logic             dout,
  output logic             doutEn,
  output logic             convBusy,
  output logic             inShutdown,
  output logic             abortPulse
);

  adcrd_link_if lnk ();

  adcrd_pin_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .csN     (csN),
    .sclk    (sclk),
    .lnk     (lnk.sync)
  );

  adcrd_core_s q;
  adcrd_core_s next_q;

  always_comb begin
    logic [4:0] newCount;
    newCount         = q.count;
    next_q           = q;
    next_q.abortPulse = 1'b0;
    unique case (q.state)
      ADCRD_SHUTDOWN: begin
        if (lnk.csFall) begin
          // result latched at select fall; frame leads with the zero byte
          next_q.state    = ADCRD_ACTIVE;
          next_q.frame    = {ADCRD_LEAD_BYTE, convResult, convSubBits};
          next_q.count    = ADCRD_CNT_RESET;
          next_q.dout     = 1'b0;
          next_q.doutEn   = 1'b1;
          next_q.busy     = 1'b1;
          next_q.shutdown = 1'b0;
        end
      end
      ADCRD_ACTIVE: begin
        if (lnk.csRise) begin
          next_q.state      = ADCRD_SHUTDOWN;
          next_q.dout       = 1'b0;
          next_q.doutEn     = 1'b0;
          next_q.busy       = 1'b0;
          next_q.shutdown   = 1'b1;
          next_q.abortPulse = q.busy;
        end else if (lnk.sclkFall) begin
          if (q.count != ADCRD_CNT_MAX) begin
            newCount = q.count + 5'h01;
          end
          next_q.count = newCount;
          if (newCount < ADCRD_CNT_MAX) begin
            next_q.dout = q.frame[ADCRD_LAST_BIT - newCount];
          end else begin
            // trailing zeros while select stays low
            next_q.dout = 1'b0;
          end
          next_q.busy = (newCount < ADCRD_CONV_DONE);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= ADCRD_CORE_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign dout       = q.dout;
  assign doutEn     = q.doutEn;
  assign convBusy   = q.busy;
  assign inShutdown = q.shutdown;
  assign abortPulse = q.abortPulse;

  sequence earlyRise_s;
    lnk.csRise && q.state == ADCRD_ACTIVE && q.busy;
  endsequence

  sequence abortDone_s;
    abortPulse && inShutdown && !doutEn;
  endsequence

  sequence frameOpen_s;
    doutEn && !dout && convBusy && !inShutdown;
  endsequence

  sequence idleOut_s;
    !doutEn && !dout && !convBusy && inShutdown;
  endsequence

  sequence normalEnd_s;
    lnk.csRise && q.state == ADCRD_ACTIVE && !q.busy;
  endsequence

  sequence lastLeadFall_s;
    lnk.sclkFall && !lnk.csRise && q.state == ADCRD_ACTIVE && q.count == ADCRD_CONV_DONE - 5'h01;
  endsequence

  sequence subHighFall_s;
    doutEn && lnk.sclkFall && !lnk.csRise && q.count == ADCRD_SUB_START - 5'h01;
  endsequence

  sequence subLowFall_s;
    doutEn && lnk.sclkFall && !lnk.csRise && q.count == ADCRD_SUB_START;
  endsequence

  dout_fall_only_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      ($changed(dout) && q.state == ADCRD_ACTIVE && $past(q.state) == ADCRD_ACTIVE)
        |-> $past(lnk.sclkFall))
    else $error("dout changed without a clock falling edge");

  lead_zeros_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      (doutEn && q.count < ADCRD_CONV_DONE) |-> (dout == 1'b0 && convBusy))
    else $error("nonzero bit during leading zero byte");

  msb_byte_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      (doutEn && q.count >= ADCRD_CONV_DONE && q.count < ADCRD_SUB_START)
        |-> dout == q.frame[ADCRD_LAST_BIT - q.count])
    else $error("result bit out of order");

  sub_bits_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      subHighFall_s |=> (dout == q.frame[1] && q.count == ADCRD_SUB_START))
    else $error("high sub bit not sent after D0");

  sub_low_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      subLowFall_s |=> (dout == q.frame[0] && q.count == ADCRD_LAST_BIT))
    else $error("low sub bit not sent last");

  abort_shutdown_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      earlyRise_s |=> abortDone_s ##1 (inShutdown && !abortPulse))
    else $error("early select rise did not abort");

  frame_latch_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      (q.state == ADCRD_SHUTDOWN && lnk.csFall)
        |=> q.frame == {ADCRD_LEAD_BYTE, $past(convResult), $past(convSubBits)})
    else $error("result not latched at select fall");

  start_outputs_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      (q.state == ADCRD_SHUTDOWN && lnk.csFall) |=> frameOpen_s)
    else $error("frame did not open with a low output");

  enable_in_frame_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      (doutEn && !lnk.csRise) |-> lnk.csLow)
    else $error("output enabled while select high");

  enable_hold_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      (q.state == ADCRD_ACTIVE && !lnk.csRise) |=> (doutEn && !inShutdown))
    else $error("output enable dropped inside a frame");

  busy_span_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      convBusy |-> (doutEn && q.count < ADCRD_CONV_DONE))
    else $error("busy outside the leading byte");

  busy_clear_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      lastLeadFall_s |=> (!convBusy && q.count == ADCRD_CONV_DONE))
    else $error("busy not cleared at the eighth falling edge");

  count_step_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      (q.state == ADCRD_ACTIVE && lnk.sclkFall && !lnk.csRise && q.count != ADCRD_CNT_MAX)
        |=> q.count == $past(q.count) + 5'h01)
    else $error("falling edge not counted");

  count_cap_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      q.count <= ADCRD_CNT_MAX)
    else $error("edge counter ran past its limit");

  trail_zeros_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      (doutEn && q.count == ADCRD_CNT_MAX) |-> !dout)
    else $error("nonzero bit after the sub bits");

  dout_hold_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      (q.state == ADCRD_ACTIVE && !lnk.sclkFall && !lnk.csRise) |=> $stable(dout))
    else $error("dout moved between falling edges");

  idle_hold_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      (q.state == ADCRD_SHUTDOWN && !lnk.csFall) |=> idleOut_s)
    else $error("outputs active while shut down");

  normal_end_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      normalEnd_s |=> idleOut_s ##0 !abortPulse)
    else $error("finished frame reported as abort");

  pulse_single_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      abortPulse |=> !abortPulse)
    else $error("abort pulse longer than one cycle");

  pulse_cause_a : assert property (
    @(posedge ref_clk) disable iff (rst)
      abortPulse |-> ($past(lnk.csRise) && $past(convBusy)))
    else $error("abort pulse without an early select rise");

endmodule : adcrd_readout

// ==== adcrd_host_model.sv ====
`timescale 1ns/100ps
module adcrd_host_model (
  input  wire logic dout,
  input  wire logic doutEn,
  output logic      csN,
  output logic      sclk
);
  logic lineBit;

  // released line floats; model it as the opposite of dout, which is cleared on release, so it reads high
  assign lineBit = doutEn ? dout : ~dout;

  initial begin
    csN  = 1'b1;
    sclk = 1'b0;
  end

  task automatic readFrame(input int nClk, output logic [23:0] word);
    word = '0;
    csN  = 1'b0;
    #300;
    for (int k = 0; k < nClk; k++) begin
      sclk = 1'b1;
      word = {word[22:0], lineBit};
      // short high phase leaves room for the slow output path
      #60;
      sclk = 1'b0;
      #140;
    end
    #100;
    csN = 1'b1;
    #200;
  endtask : readFrame
endmodule : adcrd_host_model

// ==== test_adc_result_serial_readout.sv ====
`timescale 1ns/100ps
module test_adc_result_serial_readout;
  import adcrd_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic        csN;
  logic        sclk;
  logic [13:0] convResult;
  logic [1:0]  convSubBits;
  logic        dout;
  logic        doutEn;
  logic        convBusy;
  logic        busyAtEnd;
  logic        inShutdown;
  logic        abortPulse;
  logic [23:0] word;
  logic [23:0] expWord;
  int          bad_count;
  int          compares;
  int          aborts;
  int          lens[7] = '{24, 26, 23, 8, 7, 0, 24};

  adcrd_readout adcrd_readout_i (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .csN         (csN),
    .sclk        (sclk),
    .convResult  (convResult),
    .convSubBits (convSubBits),
    .dout        (dout),
    .doutEn      (doutEn),
    .convBusy    (convBusy),
    .inShutdown  (inShutdown),
    .abortPulse  (abortPulse)
  );

  adcrd_host_model adcrd_host_model_i (
    .dout   (dout),
    .doutEn (doutEn),
    .csN    (csN),
    .sclk   (sclk)
  );

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check

  task automatic checkFlag(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask : checkFlag

  task automatic modelFrame(input int nClk, output logic [23:0] exp);
    bit bits[$];
    exp = '0;
    repeat (8) begin
      bits.push_back(1'b0);
    end
    for (int b = ADCRD_RES_W - 1; b >= 0; b--) begin
      bits.push_back(convResult[b]);
    end
    bits.push_back(convSubBits[1]);
    bits.push_back(convSubBits[0]);
    // host keeps the last 24 bits; extra clocks give zeros
    for (int k = 0; k < nClk; k++) begin
      exp = {exp[22:0], ((k < bits.size()) ? bits[k] : 1'b0)};
    end
  endtask : modelFrame

  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk) begin
    if (abortPulse === 1'b1) begin
      aborts++;
    end
  end

  // status as seen the moment select is released
  always @(posedge csN) begin
    busyAtEnd = convBusy;
  end

  // frames run up to about 6 us each
  initial begin
    #200000;
    bad_count++;
    final_report();
  end

  initial begin
    bad_count   = 0;
    compares    = 0;
    aborts      = 0;
    rst         = 1'b1;
    convResult  = '0;
    convSubBits = '0;
    void'($urandom(74431));
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    foreach (lens[i]) begin
      @(posedge ref_clk);
      #1;
      convResult  = 14'($urandom);
      convSubBits = 2'($urandom);
      aborts      = 0;
      adcrd_host_model_i.readFrame(lens[i], word);
      modelFrame(lens[i], expWord);
      check("frame", expWord, word);
      if (lens[i] == 24) begin
        check("result", 24'(convResult), 24'(word[ADCRD_SUB_W +: ADCRD_RES_W]));
      end
      check("abort", 24'(lens[i] < 8), 24'(aborts));
      checkFlag("busy at end", lens[i] < 8, busyAtEnd);
      check("shutdown", 24'h000001, 24'(inShutdown));
      checkFlag("enable", 1'b0, doutEn);
      checkFlag("busy idle", 1'b0, convBusy);
    end
    final_report();
  end
endmodule : test_adc_result_serial_readout
